// [common/servo_defines.svh]
// Register map, field positions, reset values and timing counts of the gain and torque-limit block
`ifndef SERVO_DEFINES_SVH
`define SERVO_DEFINES_SVH

`define ADDR_W          8
`define OFS_CFG         8'h00
`define OFS_RET_DELAY   8'h04
`define OFS_LEVEL_HYS   8'h08
`define OFS_RAMP        8'h0C
`define OFS_BRAKE_DELAY 8'h10
`define OFS_SET1_A      8'h14
`define OFS_SET1_B      8'h18
`define OFS_SET2_A      8'h1C
`define OFS_SET2_B      8'h20
`define OFS_TORQUE_CAP  8'h24
`define OFS_DEV_ONE     8'h28
`define OFS_DEV_TWO     8'h2C
`define OFS_OVERSPEED   8'h30
`define OFS_STATUS      8'h34

`define CFG_MODE_BIT    0
`define CFG_COND_LSB    1
`define CFG_TLSW_BIT    4
`define CFG_WARN_BIT    5
`define ST_DEV_BIT      5
`define ST_OSPD_BIT     6

`define RST_CFG         32'h0000_0000
`define RST_SET_A       32'h0064_0032
`define RST_SET_B       32'h0404_0014
`define RST_TORQUE_CAP  32'h012C_012C
`define RST_DEV         32'h0000_7530
`define RST_OVERSPEED   32'h1770_1770
`define TORQUE_CAP_MAX  16'h012C
`define TORQUE_PER_PCT  16'h0064
`define OVERSPEED_FIXED 32'h0000_1B58
`define STOP_SPEED_RPM  32'h0000_001E
`define MAX_FILTER_SHIFT 8'h0F

`define CLK_NS          5
`define TICK_NS         1000
`define TICK_CYC        ((`TICK_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// [common/servo_pkg.sv]
// Types shared by the gain and torque-limit block
package servo_pkg;
	typedef struct packed {
		logic [15:0] posGain;
		logic [15:0] spdGain;
		logic [15:0] intTime;
		logic [7:0]  fbFilt;
		logic [7:0]  tqFilt;
	} gain_set_s;

	typedef enum logic [2:0] {
		COND_ALWAYS_ONE = 3'h0,
		COND_ALWAYS_TWO = 3'h1,
		COND_EXT_INPUT  = 3'h2,
		COND_TORQUE     = 3'h3,
		COND_SPEED      = 3'h4,
		COND_DEVIATION  = 3'h5
	} cond_e;

	typedef enum logic [2:0] {
		BRK_RELEASED = 3'h1,
		BRK_WAIT     = 3'h2,
		BRK_HELD     = 3'h4
	} brake_e;
endpackage

// [tb/motor_model.sv]
// Behavioural motor, encoder and host controller beside the block
`timescale 1ns/1ps
module motor_model (
	// Clock and reset
	input wire logic               core_clk,
	input wire logic               rst,
	// Requests from the bench
	input wire logic signed [15:0] targetSpeed,
	input wire logic signed [15:0] slewStep,
	input wire logic signed [15:0] torqueReq,
	input wire logic signed [31:0] deviationReq,
	input wire logic [2:0]         pinReq,
	// Loop quantities and host pins
	output logic signed [15:0]     encoderSpeed,
	output logic signed [15:0]     torqueCommand,
	output logic signed [31:0]     positionDeviation,
	output logic                   gainSwitchPin,
	output logic                   torque_limit_select_input,
	output logic                   runCommandPin
);
	int gap;
	// Speed moves at a limited slew, so a stop takes real time
	always_comb gap = (runCommandPin ? int'(targetSpeed) : 0) - int'(encoderSpeed);
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			{encoderSpeed, torqueCommand, positionDeviation, runCommandPin} <= '0;
			{torque_limit_select_input, gainSwitchPin} <= '0;
		end else begin
			if (gap > slewStep)
				encoderSpeed <= encoderSpeed + slewStep;
			else if (gap < -slewStep)
				encoderSpeed <= encoderSpeed - slewStep;
			else
				encoderSpeed <= encoderSpeed + 16'(gap);
			torqueCommand <= torqueReq;
			positionDeviation <= deviationReq;
			{runCommandPin, torque_limit_select_input, gainSwitchPin} <= pinReq;
		end
	end
endmodule

// [tb/servo_gain_torque_properties.sv]
// Port-level assertions for the gain and torque-limit block
`timescale 1ns/1ps
`include "servo_defines.svh"
module servo_gain_torque_properties (
	// Clock and reset
	input wire logic               core_clk,
	input wire logic               rst,
	// Register bus
	input wire logic               awvalid,
	input wire logic               awready,
	input wire logic               wvalid,
	input wire logic               wready,
	input wire logic               bvalid,
	input wire logic               bready,
	input wire logic [`ADDR_W-1:0] araddr,
	input wire logic               arvalid,
	input wire logic               arready,
	input wire logic [31:0]        rdata,
	input wire logic [1:0]         rresp,
	input wire logic               rvalid,
	input wire logic               rready,
	// Pins and loop outputs
	input wire logic               runCommandPin,
	input wire logic               torque_limit_select_input,
	input wire logic signed [15:0] speedFeedback,
	input wire logic signed [15:0] torqueOut,
	input wire logic               torqueSetTwo,
	input wire logic               brake_interlock_output
);
	localparam int TORQUE_MAX = `TORQUE_CAP_MAX * `TORQUE_PER_PCT;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence writeTaken;
		awvalid && awready && wvalid && wready;
	endsequence
	// Pins pass a synchroniser first, hence six cycles
	sequence stoppedSlow;
		(!runCommandPin && speedFeedback <= 16'sh001E && speedFeedback >= -16'sh001E) [*6];
	endsequence
	chk_write_answer: assert property (writeTaken |-> ##1 !bvalid ##1 bvalid)
		else $error("write response late");
	chk_write_release: assert property (bvalid && bready |=> !bvalid)
		else $error("write response not released");
	chk_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read data late");
	chk_read_release: assert property (rvalid && rready |=> !rvalid)
		else $error("read data not released");
	chk_unmapped_read: assert property (arvalid && arready && araddr > 8'h37 |=> rresp == 2'b10 && rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_brake_release: assert property (runCommandPin [*6] |-> brake_interlock_output)
		else $error("brake held while running");
	chk_brake_drop: assert property (stoppedSlow |-> !brake_interlock_output)
		else $error("brake released after slow stop");
	chk_torque_bound: assert property (torqueOut <= TORQUE_MAX && torqueOut >= -TORQUE_MAX)
		else $error("torque beyond largest cap");
	chk_set_two_pin: assert property (!torque_limit_select_input [*5] |-> !torqueSetTwo)
		else $error("second cap set without select pin");
endmodule
bind servo_gain_torque servo_gain_torque_properties i_servo_gain_torque_properties (.*);

// [tb/tb_servo_gain_torque.sv]
// Self-checking bench for the gain and torque-limit block
`timescale 1ns/1ps
`include "servo_defines.svh"
module tb_servo_gain_torque
	import servo_pkg::*;
;
	logic core_clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, integralDisable, torqueSetTwo;
	logic gainSwitchPin, torque_limit_select_input, runCommandPin;
	logic warningOut, deviationOverflowAlarm, overspeedAlarm, brake_interlock_output;
	logic [`ADDR_W-1:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp;
	logic [2:0] pinReq = 0;
	logic signed [15:0] encoderSpeed, torqueCommand, speedFeedback, torqueOut;
	logic signed [15:0] targetSpeed = 0, slewStep = 100, torqueReq = 0;
	logic signed [31:0] positionDeviation, deviationReq = 0;
	gain_set_s activeGains;
	int num_errors, comparisons;
	localparam gain_set_s G1 = {16'h0064, 16'h0032, 16'h0404, 8'h00, 8'h00};
	localparam gain_set_s G2 = {16'h0080, 16'h0040, 16'h0200, 8'h02, 8'h03};
	servo_gain_torque i_servo_gain_torque (.*);
	motor_model i_motor_model (.*);
	initial forever #2.5 core_clk = ~core_clk;
	task automatic check(input string nm, input logic [63:0] s, input logic [63:0] e);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	// Handshakes are judged at the falling edge, where nothing moves
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, b;
		logic [1:0] r;
		int n;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(negedge core_clk);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid;
			r = bresp;
			@(posedge core_clk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			n++;
		end while (!b && n < 100);
		bready <= 1'b0;
		check("bresp", {b, r}, {1'b1, er});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic g, v;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(negedge core_clk);
			g = arvalid && arready;
			v = rvalid;
			d = rdata;
			r = rresp;
			@(posedge core_clk);
			if (g) arvalid <= 1'b0;
			n++;
		end while (!v && n < 100);
		rready <= 1'b0;
		check("rdata", d, e);
		check("rresp", {v, r}, {1'b1, er});
	endtask
	task automatic mot(input int s, st, tq, dv, input logic [2:0] p);
		@(posedge core_clk);
		targetSpeed <= 16'(s);
		slewStep <= 16'(st);
		torqueReq <= 16'(tq);
		deviationReq <= dv;
		pinReq <= p;
	endtask
	task automatic alm(input logic tl, input int dv, sp, input logic ed, eo);
		mot(sp, 100, 0, dv, {1'b1, tl, 1'b0});
		cyc(120);
		check("dev alarm", deviationOverflowAlarm, ed);
		check("overspeed", overspeedAlarm, eo);
		check("speed", speedFeedback, sp);
	endtask
	task automatic spd(input int s, input gain_set_s g);
		mot(s, 100, 0, 0, 3'b100);
		cyc(60);
		check("gains", activeGains, g);
	endtask
	task automatic conclude();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge core_clk);
		num_errors++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		rd(`OFS_CFG, `RST_CFG, 0);
		rd(`OFS_SET1_B, `RST_SET_B, 0);
		rd(`OFS_TORQUE_CAP, `RST_TORQUE_CAP, 0);
		rd(`OFS_OVERSPEED, `RST_OVERSPEED, 0);
		rd(`OFS_STATUS, 32'h0064_0000, 0);
		rd(8'h40, 0, 2'b10);
		wr(8'h40, 1, 2'b10);
		$display("END reset and map");
		wr(`OFS_SET1_B, 32'h0404_0000, 0);
		wr(`OFS_CFG, 32'h0000_0020, 0);
		wr(`OFS_TORQUE_CAP, 32'h012C_0032, 0);
		mot(0, 100, 10000, 0, 3'b100);
		cyc(20);
		check("torque", torqueOut, 5000);
		check("warn", warningOut, 1);
		wr(`OFS_TORQUE_CAP, 32'h0190_0014, 0);
		rd(`OFS_TORQUE_CAP, 32'h012C_0014, 0);
		wr(`OFS_CFG, 0, 0);
		mot(0, 100, -10000, 0, 3'b100);
		cyc(20);
		check("torque", torqueOut, -2000);
		check("warn", warningOut, 0);
		wr(`OFS_CFG, 32'h0000_0010, 0);
		mot(0, 100, 10000, 0, 3'b110);
		cyc(20);
		check("set two", torqueSetTwo, 1);
		check("torque", torqueOut, 10000);
		wr(`OFS_CFG, 0, 0);
		cyc(10);
		check("set two", torqueSetTwo, 0);
		check("torque", torqueOut, 2000);
		$display("END torque limit");
		wr(`OFS_DEV_ONE, 100, 0);
		wr(`OFS_OVERSPEED, 32'h1770_0100, 0);
		wr(`OFS_CFG, 32'h0000_0010, 0);
		alm(0, 100, 300, 1, 1);
		alm(0, 99, 200, 0, 0);
		alm(1, 100, 300, 0, 0);
		wr(`OFS_CFG, 0, 0);
		alm(1, 99, 300, 0, 0);
		alm(0, 99, 7001, 0, 1);
		$display("END alarms");
		wr(`OFS_SET2_A, 32'h0080_0040, 0);
		wr(`OFS_SET2_B, 32'h0200_0203, 0);
		wr(`OFS_RET_DELAY, 32'h0000_FFFF, 0);
		mot(0, 100, 0, 0, 3'b101);
		cyc(10);
		check("int off", integralDisable, 1);
		check("gains", activeGains, G1);
		for (int c = 0; c < 3; c++) begin
			wr(`OFS_CFG, 32'(c * 2 + 1), 0);
			cyc(10);
			check("int off", integralDisable, 0);
			check("gains", activeGains, (c == 0) ? G1 : G2);
		end
		mot(0, 100, 0, 0, 3'b100);
		cyc(10);
		check("gains", activeGains, G1);
		wr(`OFS_LEVEL_HYS, 32'h000A_0064, 0);
		wr(`OFS_RET_DELAY, 2, 0);
		wr(`OFS_CFG, 32'h0000_0009, 0);
		spd(105, G1);
		spd(120, G2);
		spd(95, G2);
		spd(80, G2);
		cyc(600);
		check("gains", activeGains, G1);
		wr(`OFS_RAMP, 1, 0);
		wr(`OFS_CFG, 32'h0000_0003, 0);
		cyc(1000);
		check("ramp", activeGains.posGain > 16'h0064 && activeGains.posGain < 16'h0080, 1);
		check("speed gain", activeGains.spdGain, 16'h0040);
		cyc(5800);
		check("gains", activeGains, G2);
		$display("END gain switching");
		wr(`OFS_BRAKE_DELAY, 3, 0);
		mot(1000, 100, 0, 0, 3'b100);
		cyc(30);
		check("brake", brake_interlock_output, 1);
		mot(1000, 1, 0, 0, 3'b000);
		cyc(300);
		check("brake", brake_interlock_output, 1);
		cyc(600);
		check("brake", brake_interlock_output, 0);
		wr(`OFS_BRAKE_DELAY, 32'h0000_FFFF, 0);
		mot(1000, 100, 0, 0, 3'b100);
		cyc(30);
		mot(1000, 10, 0, 0, 3'b000);
		cyc(60);
		check("brake", brake_interlock_output, 1);
		cyc(150);
		check("brake", brake_interlock_output, 0);
		$display("END brake");
		conclude();
	end
endmodule

// [verilog/_unused_placeholder_removed.sv]
// Intentionally empty
`timescale 1ns/1ps

// [verilog/lag_filter.sv]
// First-order lag filter with a power-of-two time constant
`timescale 1ns/1ps
`include "servo_defines.svh"
module lag_filter (
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst,
	// Sample in, time constant as a shift, filtered value out
	input  wire logic signed [15:0] din,
	input  wire logic        [7:0]  shift,
	output logic signed      [15:0] dout
);
	typedef struct packed {
		logic signed [31:0] acc;
	} state_s;

	state_s             s;
	state_s             next_s;
	logic        [3:0]  k;
	logic signed [31:0] diff;

	always_comb begin
		next_s = s;
		// Large settings only slow the filter further, so clamp to the shifter's range
		k      = (shift > `MAX_FILTER_SHIFT) ? 4'hF : shift[3:0];
		diff   = {din, 16'h0000} - s.acc;
		next_s.acc = s.acc + (diff >>> k);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign dout = s.acc[31:16];
endmodule

// [verilog/servo_gain_torque.sv]
// Gain switching, torque limit sets and running brake timing behind an AXI4-Lite register file
`timescale 1ns/1ps
`include "servo_defines.svh"

// What this block does
// RQ1 - Brake drops at lesser of delay, 30 r/min
// RQ2 - Mode bit picks PI/P or gain-set switching
// RQ3 - Proportional-only mode removes speed integral term
// RQ4 - Switching condition setting picks gain set
// RQ5 - Return to set one after delay
// RQ6 - Judgment level compared per chosen condition
// RQ7 - Hysteresis band above and below level
// RQ8 - Position gain ramps in timed steps
// RQ9 - Fixed or external conditions ignore level, delay
// RQ10 - Set two replaces all five gain values
// RQ11 - Speed feedback is low-pass filtered encoder speed
// RQ12 - Torque command passes first-order lag filter
// RQ13 - Torque capped at percent of maximum
// RQ14 - Cap writes above default are refused
// RQ15 - Warning while limiting, if selected
// RQ16 - Select input chooses cap set when enabled
// RQ17 - Deviation overflow alarm at active level
// RQ18 - Overspeed alarm above active level
// RQ19 - Overspeed levels used only with switching enabled
// RQ20 - Set two replaces cap, overflow, overspeed
module servo_gain_torque
	import servo_pkg::*;
(
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	// AXI4-Lite slave
	input  wire logic [`ADDR_W-1:0]   awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	input  wire logic [`ADDR_W-1:0]   araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	// Pins from the host controller
	input  wire logic                 gainSwitchPin,
	input  wire logic                 torque_limit_select_input,
	input  wire logic                 runCommandPin,
	// Loop quantities on this clock
	input  wire logic signed [15:0]   encoderSpeed,
	input  wire logic signed [15:0]   torqueCommand,
	input  wire logic signed [31:0]   positionDeviation,
	// Loop settings and results
	output gain_set_s                 activeGains,
	output logic                      integralDisable,
	output logic signed [15:0]        speedFeedback,
	output logic signed [15:0]        torqueOut,
	output logic                      torqueSetTwo,
	// Alarms and brake
	output logic                      warningOut,
	output logic                      deviationOverflowAlarm,
	output logic                      overspeedAlarm,
	output logic                      brake_interlock_output
);
	typedef struct packed {
		logic                awGot;
		logic                wGot;
		logic [`ADDR_W-1:0]  awAddr;
		logic [31:0]         wData;
		logic [3:0]          wStrb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
		logic [31:0]         cfg;
		logic [31:0]         retDelay;
		logic [31:0]         levelHys;
		logic [31:0]         ramp;
		logic [31:0]         brkDelay;
		gain_set_s           setOne;
		gain_set_s           setTwo;
		logic [31:0]         caps;
		logic [31:0]         devOne;
		logic [31:0]         devTwo;
		logic [31:0]         ospd;
		logic [7:0]          tickCnt;
		logic                condHit;
		logic                useTwo;
		logic [15:0]         holdCnt;
		logic [15:0]         posGain;
		logic [15:0]         rampCnt;
		brake_e              brake;
		logic [15:0]         brkCnt;
		logic signed [15:0]  torque;
		logic                limiting;
		logic                warn;
		logic                devAlarm;
		logic                ospdAlarm;
		logic                devSticky;
		logic                ospdSticky;
		logic                tlTwo;
		logic                intOff;
	} state_s;

	state_s             s;
	state_s             next_s;
	logic [2:0]         pins;
	logic               gainPin;
	logic               tlSelPin;
	logic               runCmd;
	logic signed [15:0] speedFilt;
	logic signed [15:0] torqueFilt;
	gain_set_s          setNow;

	sync2 #(.W(3)) u_pins (
		.core_clk (core_clk),
		.rst      (rst),
		.din      ({gainSwitchPin, torque_limit_select_input, runCommandPin}),
		.dout     (pins)
	);
	assign gainPin  = pins[2];
	assign tlSelPin = pins[1];
	assign runCmd   = pins[0];

	assign setNow = s.useTwo ? s.setTwo : s.setOne; // RQ10

	lag_filter u_speed_filter (
		.core_clk (core_clk),
		.rst      (rst),
		.din      (encoderSpeed),
		.shift    (setNow.fbFilt), // RQ11
		.dout     (speedFilt)
	);

	lag_filter u_torque_filter (
		.core_clk (core_clk),
		.rst      (rst),
		.din      (torqueCommand),
		.shift    (setNow.tqFilt), // RQ12
		.dout     (torqueFilt)
	);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] mag(input logic signed [31:0] v);
		return v[31] ? 32'(-v) : 32'(v);
	endfunction

	// Cap halves above the drive's ceiling keep their old value
	function automatic logic [15:0] capKeep(input logic [15:0] old, input logic [15:0] nw);
		return (nw > `TORQUE_CAP_MAX) ? old : nw; // RQ14
	endfunction

	always_comb begin
		logic [31:0] wv, val, lvl, hys, upper, lower;
		logic [31:0] capMag, tqMag, spdMag, devLvl, ospdLvl;
		logic        devNow, ospdNow, clrDev, clrOspd, target;
		logic [15:0] tgtGain;
		cond_e       cond;
		wv      = '0;
		val     = '0;
		lvl     = '0;
		hys     = '0;
		upper   = '0;
		lower   = '0;
		capMag  = '0;
		tqMag   = '0;
		spdMag  = '0;
		devLvl  = '0;
		ospdLvl = '0;
		devNow  = 1'b0;
		ospdNow = 1'b0;
		clrDev  = 1'b0;
		clrOspd = 1'b0;
		target  = 1'b0;
		tgtGain = '0;
		cond    = cond_e'(s.cfg[`CFG_COND_LSB +: 3]);
		next_s  = s;

		next_s.tickCnt = (s.tickCnt == 8'(`TICK_CYC - 1)) ? 8'h00 : s.tickCnt + 8'h01;

		// Write channel: address and data latch in either order
		if (awvalid && !s.awGot && !s.bvalid) begin
			next_s.awGot  = 1'b1;
			next_s.awAddr = awaddr;
		end
		if (wvalid && !s.wGot && !s.bvalid) begin
			next_s.wGot  = 1'b1;
			next_s.wData = wdata;
			next_s.wStrb = wstrb;
		end
		if (s.awGot && s.wGot) begin
			next_s.awGot  = 1'b0;
			next_s.wGot   = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = 2'h0;
			case ({s.awAddr[`ADDR_W-1:2], 2'h0})
				`OFS_CFG:         next_s.cfg = merge(s.cfg, s.wData, s.wStrb);
				`OFS_RET_DELAY:   next_s.retDelay = merge(s.retDelay, s.wData, s.wStrb);
				`OFS_LEVEL_HYS:   next_s.levelHys = merge(s.levelHys, s.wData, s.wStrb);
				`OFS_RAMP:        next_s.ramp = merge(s.ramp, s.wData, s.wStrb);
				`OFS_BRAKE_DELAY: next_s.brkDelay = merge(s.brkDelay, s.wData, s.wStrb);
				`OFS_SET1_A:      next_s.setOne[63:32] = merge(s.setOne[63:32], s.wData, s.wStrb);
				`OFS_SET1_B:      next_s.setOne[31:0] = merge(s.setOne[31:0], s.wData, s.wStrb);
				`OFS_SET2_A:      next_s.setTwo[63:32] = merge(s.setTwo[63:32], s.wData, s.wStrb);
				`OFS_SET2_B:      next_s.setTwo[31:0] = merge(s.setTwo[31:0], s.wData, s.wStrb);
				`OFS_TORQUE_CAP: begin
					wv = merge(s.caps, s.wData, s.wStrb);
					next_s.caps = {capKeep(s.caps[31:16], wv[31:16]), capKeep(s.caps[15:0], wv[15:0])};
				end
				`OFS_DEV_ONE:     next_s.devOne = merge(s.devOne, s.wData, s.wStrb);
				`OFS_DEV_TWO:     next_s.devTwo = merge(s.devTwo, s.wData, s.wStrb);
				`OFS_OVERSPEED:   next_s.ospd = merge(s.ospd, s.wData, s.wStrb);
				`OFS_STATUS: begin
					clrDev  = s.wStrb[0] & s.wData[`ST_DEV_BIT];
					clrOspd = s.wStrb[0] & s.wData[`ST_OSPD_BIT];
				end
				default:          next_s.bresp = 2'h2;
			endcase
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end

		// Read channel: one request at a time, answered on the next edge
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		if (arvalid && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = 2'h0;
			case ({araddr[`ADDR_W-1:2], 2'h0})
				`OFS_CFG:         next_s.rdata = s.cfg;
				`OFS_RET_DELAY:   next_s.rdata = s.retDelay;
				`OFS_LEVEL_HYS:   next_s.rdata = s.levelHys;
				`OFS_RAMP:        next_s.rdata = s.ramp;
				`OFS_BRAKE_DELAY: next_s.rdata = s.brkDelay;
				`OFS_SET1_A:      next_s.rdata = s.setOne[63:32];
				`OFS_SET1_B:      next_s.rdata = s.setOne[31:0];
				`OFS_SET2_A:      next_s.rdata = s.setTwo[63:32];
				`OFS_SET2_B:      next_s.rdata = s.setTwo[31:0];
				`OFS_TORQUE_CAP:  next_s.rdata = s.caps;
				`OFS_DEV_ONE:     next_s.rdata = s.devOne;
				`OFS_DEV_TWO:     next_s.rdata = s.devTwo;
				`OFS_OVERSPEED:   next_s.rdata = s.ospd;
				`OFS_STATUS: begin
					next_s.rdata = {s.posGain, 9'h000, s.ospdSticky, s.devSticky, (s.brake != BRK_HELD),
						s.limiting, s.tlTwo, s.intOff, s.useTwo};
				end
				default: begin
					next_s.rdata = '0;
					next_s.rresp = 2'h2;
				end
			endcase
		end

		// Gain switching condition with hysteresis around the judgment level
		lvl   = {16'h0000, s.levelHys[15:0]};
		hys   = {16'h0000, s.levelHys[31:16]};
		upper = lvl + hys; // RQ7
		lower = (lvl > hys) ? lvl - hys : 32'h0000_0000; // RQ7
		case (cond)
			COND_TORQUE:    val = mag(32'(torqueFilt)); // RQ6
			COND_SPEED:     val = mag(32'(speedFilt)); // RQ6
			COND_DEVIATION: val = mag(positionDeviation); // RQ6
			default:        val = '0;
		endcase
		if (!s.condHit && val > upper) begin
			next_s.condHit = 1'b1;
		end else if (s.condHit && val < lower) begin
			next_s.condHit = 1'b0;
		end

		case (cond)
			COND_ALWAYS_ONE: target = 1'b0; // RQ9
			COND_ALWAYS_TWO: target = 1'b1; // RQ9
			COND_EXT_INPUT:  target = gainPin; // RQ9
			COND_TORQUE, COND_SPEED, COND_DEVIATION: begin
				target = s.condHit || (s.holdCnt != 16'h0000); // RQ4
			end
			default:         target = 1'b0;
		endcase

		// Return delay counts ticks from the moment the condition drops
		// No hold pending when entering a level condition that was never met
		if (cond < COND_TORQUE) begin
			next_s.holdCnt = '0; // RQ9
		end else if (s.condHit) begin
			next_s.holdCnt = s.retDelay[15:0]; // RQ5
		end else if (s.holdCnt != 16'h0000 && s.tickCnt == 8'h00) begin
			next_s.holdCnt = s.holdCnt - 16'h0001; // RQ5
		end

		// Mode bit clear: the switch input selects proportional-only instead of gain two
		if (s.cfg[`CFG_MODE_BIT]) begin
			next_s.useTwo = target; // RQ2
			next_s.intOff = 1'b0;
		end else begin
			next_s.useTwo = 1'b0; // RQ2
			next_s.intOff = gainPin; // RQ3
		end

		// Position gain walks one unit per ramp interval; other gains switch at once
		tgtGain = setNow.posGain;
		if (!s.cfg[`CFG_MODE_BIT] || s.ramp[15:0] == 16'h0000) begin
			next_s.posGain = tgtGain;
			next_s.rampCnt = '0;
		end else if (s.posGain != tgtGain && s.tickCnt == 8'h00) begin
			if (s.rampCnt + 16'h0001 >= s.ramp[15:0]) begin
				next_s.rampCnt = '0;
				next_s.posGain = (s.posGain < tgtGain) ? s.posGain + 16'h0001 : s.posGain - 16'h0001; // RQ8
			end else begin
				next_s.rampCnt = s.rampCnt + 16'h0001; // RQ8
			end
		end

		// Torque limit set, cap and warning
		next_s.tlTwo = s.cfg[`CFG_TLSW_BIT] & tlSelPin; // RQ16
		capMag = 32'((s.tlTwo ? s.caps[31:16] : s.caps[15:0]) * `TORQUE_PER_PCT); // RQ20
		tqMag  = mag(32'(torqueFilt));
		next_s.limiting = (tqMag > capMag);
		if (tqMag > capMag) begin
			next_s.torque = torqueFilt[15] ? 16'(-capMag) : capMag[15:0]; // RQ13
		end else begin
			next_s.torque = torqueFilt;
		end
		next_s.warn = s.cfg[`CFG_WARN_BIT] & s.limiting; // RQ15

		// Alarms against the active set; set wins over a software clear
		devLvl  = s.tlTwo ? s.devTwo : s.devOne; // RQ20
		devNow  = (mag(positionDeviation) >= devLvl); // RQ17
		ospdLvl = s.tlTwo ? {16'h0000, s.ospd[31:16]} : {16'h0000, s.ospd[15:0]}; // RQ20
		if (!s.cfg[`CFG_TLSW_BIT]) begin
			ospdLvl = `OVERSPEED_FIXED; // RQ19
		end
		spdMag  = mag(32'(speedFilt));
		ospdNow = (spdMag > ospdLvl); // RQ18
		next_s.devAlarm   = devNow;
		next_s.ospdAlarm  = ospdNow;
		next_s.devSticky  = (s.devSticky & ~clrDev) | devNow;
		next_s.ospdSticky = (s.ospdSticky & ~clrOspd) | ospdNow;

		// Brake interlock when the run command drops while turning
		case (s.brake)
			BRK_RELEASED: begin
				if (!runCmd) begin
					next_s.brkCnt = '0;
					next_s.brake  = (spdMag <= `STOP_SPEED_RPM) ? BRK_HELD : BRK_WAIT; // RQ1
				end
			end
			BRK_WAIT: begin
				if (s.tickCnt == 8'h00) begin
					next_s.brkCnt = s.brkCnt + 16'h0001;
				end
				if (runCmd) begin
					next_s.brake = BRK_RELEASED;
				end else if (spdMag <= `STOP_SPEED_RPM || s.brkCnt >= s.brkDelay[15:0]) begin
					next_s.brake = BRK_HELD; // RQ1
				end
			end
			BRK_HELD: begin
				if (runCmd) begin
					next_s.brake = BRK_RELEASED;
				end
			end
			default: next_s.brake = BRK_HELD;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s          <= '0;
			s.cfg      <= `RST_CFG;
			s.setOne   <= {`RST_SET_A, `RST_SET_B};
			s.setTwo   <= {`RST_SET_A, `RST_SET_B};
			s.caps     <= `RST_TORQUE_CAP;
			s.devOne   <= `RST_DEV;
			s.devTwo   <= `RST_DEV;
			s.ospd     <= `RST_OVERSPEED;
			s.posGain  <= 16'(`RST_SET_A >> 16);
			s.brake    <= BRK_HELD;
		end else begin
			s <= next_s;
		end
	end

	// Handshake readies are combinational; everything else comes from state
	assign awready = !s.awGot && !s.bvalid;
	assign wready  = !s.wGot && !s.bvalid;
	assign arready = !s.rvalid;
	assign bvalid  = s.bvalid;
	assign bresp   = s.bresp;
	assign rvalid  = s.rvalid;
	assign rdata   = s.rdata;
	assign rresp   = s.rresp;

	assign activeGains            = {s.posGain, setNow.spdGain, setNow.intTime, setNow.fbFilt, setNow.tqFilt};
	assign integralDisable        = s.intOff;
	assign speedFeedback          = speedFilt;
	assign torqueOut              = s.torque;
	assign torqueSetTwo           = s.tlTwo;
	assign warningOut             = s.warn;
	assign deviationOverflowAlarm = s.devAlarm;
	assign overspeedAlarm         = s.ospdAlarm;
	assign brake_interlock_output = (s.brake != BRK_HELD);
endmodule

// [verilog/sync2.sv]
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} state_s;

	state_s s;
	state_s next_s;

	always_comb begin
		next_s        = s;
		next_s.first  = din;
		next_s.second = s.first;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign dout = s.second;
endmodule
